// *** logic/prefetch_cache.sv ***
// circular instruction prefetch cache with look-ahead and look-back
// assumes in-order memory answers and a decoder holding its pc
`timescale 1ns/1ns
module prefetch_cache
  import prefetch_cache_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        clkEn,
  input  wire logic [31:0] resetPc,
  output logic             memReqValid,
  output logic      [31:0] memReqAddr,
  input  wire logic        memReqReady,
  input  wire logic        memRespValid,
  input  wire logic [31:0] memRespData,
  output logic             memRespReady,
  input  wire logic [31:0] programCounter,
  input  wire logic [1:0]  decLen,
  output decode_t          decOut,
  input  next_instr_t      nextInstr,
  input  wire logic        execMem,
  input  branch_t          branch,
  input  wire logic        logicWrite,
  input  wire logic [31:0] logicData,
  input  wire logic        frameExec,
  input  wire logic        returnExec,
  input  wire logic [31:0] savedStatus,
  output logic             loopHold
);
  // storage, one flop word per slot
  logic [31:0] cacheMem [CACHE_WORDS];
  logic [CACHE_WORDS-1:0] slotValid;  // word landed
  logic [31:0] ahead;                 // forward bound
  logic [31:0] back;                  // backward bound
  logic        epoch;                 // stream generation
  logic        firstPending;          // fetch ahead itself
  logic        initPending;           // load from reset pc
  logic [1:0]  holdCnt;               // memory hold count
  logic        tagReady;              // pipeline has room
  logic        tagValid;              // oldest tag present
  logic [TAG_W-1:0] tagOut;           // epoch and slot
  logic        respValid;             // buffered word
  logic [31:0] respData;

  // address helpers
  wire [31:0] pcWord   = programCounter & WORD_MASK;
  wire [31:0] lastHalf = programCounter
                       + ({30'h0, decLen - LEN_ONE} * HALF_STEP);
  wire [31:0] lastWord = lastHalf & WORD_MASK;
  wire [31:0] span     = ahead - back;

  // word within window and landed
  function automatic logic present(input logic [31:0] w);
    present = ((w - back) <= span)
            & slotValid[w[SLOT_MSB:SLOT_LSB]];
  endfunction : present

  function automatic logic targetCached(input logic [31:0] t);
    if (t < programCounter) begin
      targetCached = (t & WORD_MASK) >= back;
    end else begin
      targetCached = (t & WORD_MASK) <= ahead + FWD_SLACK;
    end
  endfunction : targetCached

  // branch classification
  wire brShort    = (branch.kind == BR_SHORT)
                  | (branch.kind == BR_SHORT_DELAYED);
  wire brForward  = branch.target >= programCounter;
  wire brCached   = brShort & ~branch.delaySlot
                  & targetCached(branch.target);
  // delayed short forward miss under hold
  wire brWaitHold = (branch.kind == BR_SHORT_DELAYED)
                  & brForward & loopHold & ~branch.delaySlot;
  wire brKeep     = brCached | brWaitHold;
  // everything else flushes; long kinds never test cache
  wire flushNow   = (branch.taken & ~brKeep) | initPending;
  wire [31:0] flushAddr = initPending ? resetPc : branch.target;

  // exemption for cached forward short branch
  wire nextExempt = nextInstr.shortBranch
                  & (nextInstr.target >= programCounter)
                  & targetCached(nextInstr.target);
  wire pauseNow   = nextInstr.accessesMem
                  | (nextInstr.mayBranch & ~nextExempt)
                  | execMem | (holdCnt != 2'h0);
  // eight words past pc halts; a pc beyond the bound never does
  wire [31:0] aheadGap = ahead - pcWord;
  wire haltNow = ~firstPending & ~aheadGap[$high(aheadGap)] & (aheadGap >= AHEAD_LIMIT);
  wire busFree    = ~memReqValid | memReqReady;
  wire issue      = clkEn & ~flushNow & ~pauseNow & ~haltNow
                  & tagReady & busFree;
  // address of the newly started word
  wire [31:0] issueAddr = firstPending ? ahead : ahead + WORD_STEP;
  wire [SLOT_W-1:0] issueSlot = issueAddr[SLOT_MSB:SLOT_LSB];
  wire overwrite  = issue & ~firstPending
                  & ((issueAddr - back) >= WRAP_SPAN);

  // drain side stalls while flushing
  wire drainReady = ~flushNow;
  wire drain      = clkEn & respValid & tagValid & drainReady;
  wire drainSlotOk = drain & (tagOut[TAG_W-1] == epoch);
  wire [SLOT_W-1:0] drainSlot = tagOut[SLOT_W-1:0];

  // two-deep pipeline of outstanding fetch tags
  skid_buffer #(
    .W     (TAG_W),
    .DEPTH (BUF_DEPTH)
  ) tagQueue (
    .mclk     (mclk),
    .resetn   (resetn),
    .clkEn    (clkEn),
    .inValid  (issue),
    .inData   ({epoch, issueSlot}),
    .inReady  (tagReady),
    .outValid (tagValid),
    .outData  (tagOut),
    .outReady (drain)
  );

  // answers from the bus wait here
  skid_buffer #(
    .W     (32),
    .DEPTH (BUF_DEPTH)
  ) respBuffer (
    .mclk     (mclk),
    .resetn   (resetn),
    .clkEn    (clkEn),
    .inValid  (memRespValid),
    .inData   (memRespData),
    .inReady  (memRespReady),
    .outValid (respValid),
    .outData  (respData),
    .outReady (drain)
  );

  bound_counter aheadCounter (
    .mclk      (mclk),
    .resetn    (resetn),
    .clkEn     (clkEn),
    .load      (flushNow),
    .loadValue (flushAddr),
    .step      (issue & ~firstPending),
    .value     (ahead)
  );

  bound_counter backCounter (
    .mclk      (mclk),
    .resetn    (resetn),
    .clkEn     (clkEn),
    .load      (flushNow),
    .loadValue (flushAddr),
    .step      (overwrite),
    .value     (back)
  );

  // reset waits one cycle for the pc
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      initPending  <= 1'b1;
      firstPending <= 1'b1;
      epoch        <= 1'b0;
    end else if (clkEn) begin
      initPending <= 1'b0;
      if (flushNow) begin
        firstPending <= 1'b1;
        epoch        <= ~epoch;
      end else if (issue) begin
        firstPending <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      holdCnt <= 2'h0;
    end else if (clkEn) begin
      if (execMem) begin
        holdCnt <= MEM_HOLD - 2'h1;
      end else if (holdCnt != 2'h0) begin
        holdCnt <= holdCnt - 2'h1;
      end
    end
  end

  // bus request held until taken
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      memReqValid <= 1'b0;
      memReqAddr  <= '0;
    end else if (clkEn) begin
      if (issue) begin
        memReqValid <= 1'b1;
        memReqAddr  <= issueAddr;
      end else if (memReqReady) begin
        memReqValid <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      slotValid <= '0;
    end else if (clkEn) begin
      if (flushNow) begin
        slotValid <= '0;
      end else begin
        if (issue) begin
          slotValid[issueSlot] <= 1'b0;
        end
        if (drainSlotOk) begin
          slotValid[drainSlot] <= 1'b1;
        end
      end
    end
  end

  // word storage
  always_ff @(posedge mclk) begin
    if (clkEn && drainSlotOk) begin
      cacheMem[drainSlot] <= respData;
    end
  end

  wire [HALF_MSB-HALF_LSB:0] hIdx0 = programCounter[HALF_MSB:HALF_LSB];
  wire [HALF_MSB-HALF_LSB:0] hIdx1 = hIdx0 + 6'h1;
  wire [HALF_MSB-HALF_LSB:0] hIdx2 = hIdx0 + 6'h2;
  // lower address holds the upper half
  function automatic logic [HALF_W-1:0] halfAt(
    input logic [HALF_MSB-HALF_LSB:0] h);
    halfAt = h[0] ? cacheMem[h[5:1]][15:0] : cacheMem[h[5:1]][31:16];
  endfunction : halfAt
  // only the needed words must be present
  wire decAvail = present(pcWord) & present(lastWord);

  // registered decode view
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      decOut <= '0;
    end else if (clkEn) begin
      decOut.ready <= decAvail & ~flushNow;
      decOut.hw0   <= halfAt(hIdx0);
      decOut.hw1   <= halfAt(hIdx1);
      decOut.hw2   <= halfAt(hIdx2);
    end
  end

  wire brClears = branch.taken & (branch.kind != BR_SHORT_DELAYED)
                & (branch.kind != BR_LONG_DELAYED)
                & (branch.kind != BR_RETURN);
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      loopHold <= 1'b0;
    end else if (clkEn) begin
      if (returnExec) begin
        loopHold <= savedStatus[LOOP_HOLD_BIT];
      end else if (frameExec || brClears) begin
        loopHold <= 1'b0;
      end else if (logicWrite) begin
        loopHold <= logicData[LOOP_HOLD_BIT];
      end
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn || !clkEn);

  aheadStep_a: assert property (
    issue && !firstPending |=> ahead == $past(ahead) + WORD_STEP)
    else $error("forward bound did not step by four");
  haltLimit_a: assert property (
    issue |-> firstPending || pcWord > ahead || (ahead - pcWord) < AHEAD_LIMIT)
    else $error("fetch issued past eight words");
  backStep_a: assert property (
    overwrite && !flushNow |=> back == $past(back) + WORD_STEP)
    else $error("backward bound not advanced");
  memPause_a: assert property (
    execMem |-> !issue)
    else $error("fetch during memory cycle");
  memHold_a: assert property (
    execMem ##1 !execMem |-> !issue)
    else $error("memory hold shorter than two cycles");
  flushLoad_a: assert property (
    flushNow |=> ahead == ($past(flushAddr) & WORD_MASK)
             && back == ahead)
    else $error("flush did not load both bounds");
  cachedKeep_a: assert property (
    branch.taken && brCached && !initPending |-> !flushNow)
    else $error("cached branch target flushed");
  longFlush_a: assert property (
    branch.taken && branch.kind == BR_LONG |-> flushNow)
    else $error("long branch did not flush");
  loopClear_a: assert property (
    branch.taken && branch.kind == BR_LONG && !returnExec
    |=> !loopHold)
    else $error("loop-hold not cleared");
  decodeWait_a: assert property (
    flushNow |=> !decOut.ready)
    else $error("decode ready right after flush");

  flushSeen_c: cover property (branch.taken && flushNow);
  holdWait_c:  cover property (branch.taken && brWaitHold);
  overrun_c:   cover property (overwrite);
endmodule : prefetch_cache

// *** logic/prefetch_cache_pkg.sv ***
// constants and carriers for the circular prefetch cache
// assumes one 20 MHz clock and a word-wide memory bus
package prefetch_cache_pkg;
  // widths
  localparam int CACHE_WORDS = 32;
  localparam int SLOT_W      = 5;
  localparam int HALF_W      = 16;
  localparam int BUF_DEPTH   = 2;
  localparam int TAG_W       = 6;
  // address field positions and the status loop-hold bit
  localparam int SLOT_LSB    = 2;
  localparam int SLOT_MSB    = 6;
  localparam int HALF_LSB    = 1;
  localparam int HALF_MSB    = 6;
  localparam int LOOP_HOLD_BIT = 4;
  // byte steps and spans
  localparam logic [31:0] WORD_STEP   = 32'h4;
  localparam logic [31:0] HALF_STEP   = 32'h2;
  localparam logic [31:0] FWD_SLACK   = 32'h8;
  localparam logic [31:0] AHEAD_LIMIT = 32'h20;
  localparam logic [31:0] WRAP_SPAN   = 32'h80;
  localparam logic [31:0] WORD_MASK   = 32'hffff_fffc;
  // cycle and length counts
  localparam logic [1:0]  MEM_HOLD    = 2'h2;
  localparam logic [1:0]  LEN_ONE     = 2'h1;
  // kinds of taken branch
  typedef enum logic [2:0] {
    BR_SHORT, BR_SHORT_DELAYED, BR_LONG, BR_LONG_DELAYED,
    BR_RETURN, BR_OTHER
  } branch_kind_t;
  // taken branch event
  typedef struct packed {
    logic         taken;
    branch_kind_t kind;
    logic         delaySlot;
    logic [31:0]  target;
  } branch_t;
  // instruction about to execute
  typedef struct packed {
    logic        accessesMem;
    logic        mayBranch;
    logic        shortBranch;
    logic [31:0] target;
  } next_instr_t;
  // halfwords handed to decode
  typedef struct packed {
    logic              ready;
    logic [HALF_W-1:0] hw0;
    logic [HALF_W-1:0] hw1;
    logic [HALF_W-1:0] hw2;
  } decode_t;
endpackage : prefetch_cache_pkg

// *** logic/bound_counter.sv ***
// one bound counter of the cache window
// assumes load and step never matter in the same cycle
`timescale 1ns/1ns
module bound_counter
  import prefetch_cache_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        clkEn,
  input  wire logic        load,
  input  wire logic [31:0] loadValue,
  input  wire logic        step,
  output logic      [31:0] value
);
  // load wins over step
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      value <= '0;
    end else if (clkEn) begin
      if (load) begin
        value <= loadValue & WORD_MASK;
      end else if (step) begin
        value <= value + WORD_STEP;
      end
    end
  end
endmodule : bound_counter

// *** logic/skid_buffer.sv ***
// two-entry buffer with valid and ready on both sides
// assumes the sink may stall at will
`timescale 1ns/1ns
module skid_buffer
  import prefetch_cache_pkg::*;
#(
  parameter int W     = 32,
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic         clkEn,
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  output logic              outValid,
  output logic      [W-1:0] outData,
  input  wire logic         outReady
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] store [DEPTH];  // entries
  logic [PW-1:0] wrIdx;         // write index
  logic [PW-1:0] rdIdx;         // read index
  logic [PW:0]   count;         // entries held
  logic [PW:0]   next_count;
  wire push = clkEn & inValid & inReady;
  wire pop  = clkEn & outValid & outReady;
  assign outValid   = count != '0;
  assign outData    = store[rdIdx];
  assign next_count = count + (PW+1)'(push) - (PW+1)'(pop);
  // pointers, count and registered ready
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wrIdx   <= '0;
      rdIdx   <= '0;
      count   <= '0;
      inReady <= 1'b1;
    end else if (clkEn) begin
      if (push) begin
        store[wrIdx] <= inData;
        wrIdx        <= wrIdx + 1'b1;
      end
      if (pop) begin
        rdIdx <= rdIdx + 1'b1;
      end
      count   <= next_count;
      inReady <= next_count != (PW+1)'(DEPTH);
    end
  end
endmodule : skid_buffer

// *** test/mem_bus_model.sv ***
// memory bus model answering word fetches in request order
// assumes requests stand until taken; stalls come from the bench
`timescale 1ns/1ns
module mem_bus_model
  import prefetch_cache_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        stallReq,
  input  wire logic        stallResp,
  input  wire logic        memReqValid,
  input  wire logic [31:0] memReqAddr,
  output logic             memReqReady,
  output logic             memRespValid,
  output logic      [31:0] memRespData,
  input  wire logic        memRespReady
);
  logic [31:0] pend[$];  // taken addresses not yet answered
  logic        give;     // an answer stands next cycle
  // take, answer in order, hold an answer until accepted
  always @(posedge mclk) begin
    if (!resetn) begin
      pend.delete();
      memReqReady  <= 1'b1;
      memRespValid <= 1'b0;
      memRespData  <= 32'h0;
    end else begin
      if (memRespValid && memRespReady) begin
        void'(pend.pop_front());
      end
      if (memReqValid && memReqReady) begin
        pend.push_back(memReqAddr);
      end
      give = (pend.size() > 0) && (!stallResp || (memRespValid && !memRespReady));
      memReqReady  <= !stallReq;
      memRespValid <= give;
      // released data line shows the inverse, not the old word
      memRespData  <= give ? {pend[0][17:2] ^ 16'h5a3c, ~pend[0][17:2]} : ~memRespData;
    end
  end
endmodule : mem_bus_model

// *** test/prefetch_cache_tb.sv ***
// self-checking bench for the circular prefetch cache
// assumes the memory model above and one 20 MHz clock
`timescale 1ns/1ns
module prefetch_cache_tb
  import prefetch_cache_pkg::*;
;
  localparam logic [31:0] BOOT_PC = 32'h0000_1f40;
  localparam logic [2:0]  KND [11] = '{3'h0, 3'h0, 3'h1, 3'h0, 3'h2, 3'h0, 3'h1, 3'h1,
                                       3'h3, 3'h4, 3'h5};
  localparam int          OFF [11] = '{8, 12, -36, -160, -36, 8, 20, 20, -36, 8, 8};
  localparam logic [10:0] DLY = 11'h020;  // case sits in a delay slot
  localparam logic [10:0] HLD = 11'h740;  // loop hold preset
  localparam logic [10:0] FLS = 11'h7ba;  // flush expected
  typedef struct packed {
    logic [1:0]  len;
    logic [15:0] h0;
    logic [15:0] h1;
    logic [15:0] h2;
  } note_t;
  logic mclk, resetn, clkEn, memReqValid, memReqReady, memRespValid, memRespReady;
  logic logicWrite, frameExec, returnExec, execMem, loopHold, stallReq, stallResp;
  logic stormy, pulseMem, expFlush;
  logic [31:0] memReqAddr, memRespData, programCounter, logicData, savedStatus;
  logic [31:0] rng = 32'h0000_b241, pc = BOOT_PC, expNext = BOOT_PC, lastTake, base, tgt, d;
  logic [1:0]  decLen;
  decode_t      decOut;
  next_instr_t  nextInstr;
  branch_t      branch;
  branch_kind_t k;
  note_t        expQ[$];  // expected decode results, oldest first
  note_t        nt;
  int fails = 0, nCompared = 0, nTake = 0, m, c;

  prefetch_cache dut (.mclk(mclk), .resetn(resetn), .clkEn(clkEn), .resetPc(BOOT_PC),
    .memReqValid(memReqValid), .memReqAddr(memReqAddr), .memReqReady(memReqReady),
    .memRespValid(memRespValid), .memRespData(memRespData), .memRespReady(memRespReady),
    .programCounter(programCounter), .decLen(decLen), .decOut(decOut),
    .nextInstr(nextInstr), .execMem(execMem), .branch(branch), .logicWrite(logicWrite),
    .logicData(logicData), .frameExec(frameExec), .returnExec(returnExec),
    .savedStatus(savedStatus), .loopHold(loopHold));
  mem_bus_model mem (.mclk(mclk), .resetn(resetn), .stallReq(stallReq),
    .stallResp(stallResp), .memReqValid(memReqValid), .memReqAddr(memReqAddr),
    .memReqReady(memReqReady), .memRespValid(memRespValid), .memRespData(memRespData),
    .memRespReady(memRespReady));

  // free-running clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // xorshift source
  function automatic logic [31:0] nextRand();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : nextRand
  // halfword content as the memory model lays it out
  function automatic logic [15:0] hwAt(input logic [31:0] a);
    logic [31:0] w;
    w = {a[17:2] ^ 16'h5a3c, ~a[17:2]};
    return a[1] ? w[15:0] : w[31:16];
  endfunction : hwAt
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // verdict and end of run
  task automatic close_out();
    $display("compared %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  // present one instruction and wait for its halfwords
  task automatic dec(input logic [31:0] p, input logic [1:0] l);
    int i;
    @(negedge mclk);
    programCounter = p;
    decLen = l;
    expQ.push_back('{l, hwAt(p), hwAt(p + HALF_STEP), hwAt(p + WORD_STEP)});
    for (i = 0; i < 300; i++) begin
      @(negedge mclk);
      if (decOut.ready === 1'b1) break;
    end
    if (i == 300) begin
      fails++;
      close_out();
    end
  endtask : dec
  // n two-halfword instructions in a row
  task automatic step2(input int n);
    repeat (n) begin
      dec(pc, 2'h2);
      pc = pc + WORD_STEP;
    end
  endtask : step2
  // decode results against the oldest note
  always @(posedge mclk) begin
    #1;
    if (decOut.ready === 1'b1 && expQ.size() > 0) begin
      nt = expQ.pop_front();
      check({16'h0, decOut.hw0}, {16'h0, nt.h0});
      if (nt.len > 2'h1) check({16'h0, decOut.hw1}, {16'h0, nt.h1});
      if (nt.len > 2'h2) check({16'h0, decOut.hw2}, {16'h0, nt.h2});
    end
  end
  // fetch addresses ascend by a word, restart at a flush target
  always @(posedge mclk) begin
    if (resetn && memReqValid === 1'b1 && memReqReady) begin
      check(memReqAddr, expNext);
      expNext = memReqAddr + WORD_STEP;
      lastTake = memReqAddr;
      nTake++;
    end
    if (resetn && branch.taken && expFlush) expNext = branch.target & WORD_MASK;
  end
  // far-side stalls and alternating memory cycles
  always @(negedge mclk) begin
    d = nextRand();
    stallReq = stormy & d[0] & d[1];
    stallResp = stormy & d[2] & d[3];
    if (pulseMem) execMem = ~execMem;
  end

  initial begin
    {resetn, logicWrite, frameExec, returnExec, execMem, stormy, pulseMem, expFlush} = '0;
    {clkEn, decLen, nextInstr, branch, logicData, savedStatus} = {1'b1, 2'h1, 136'h0};
    programCounter = BOOT_PC;
    repeat (6) @(negedge mclk);
    resetn = 1'b1;
    check({31'h0, memRespReady}, 32'h1);
    check({31'h0, memReqValid}, 32'h0);
    repeat (30) @(negedge mclk);
    check(nTake, 32'h9);
    stormy = 1'b1;
    repeat (70) begin
      decLen = 2'(nextRand() % 3) + 2'h1;
      dec(pc, decLen);
      pc = pc + {29'h0, decLen, 1'b0};
    end
    stormy = 1'b0;
    // memory access, possible branch, alternating memory cycles
    for (m = 0; m < 4; m++) begin
      // let prefetch settle at its eight-word limit first
      repeat (32) @(negedge mclk);
      nextInstr.accessesMem = (m == 0);
      nextInstr.mayBranch = (m == 1) || (m == 3);
      // cached forward short branch is exempt from the pause
      nextInstr.shortBranch = (m == 3);
      nextInstr.target = pc + 32'h20;
      pulseMem = (m == 2);
      repeat (2) @(negedge mclk);
      base = nTake;
      step2(4);
      check({31'h0, nTake != base}, {31'h0, m == 3});
      @(negedge mclk);
      pulseMem = 1'b0;
      execMem = 1'b0;
      nextInstr = '0;
      repeat (12) @(negedge mclk);
      check({31'h0, nTake > base}, 32'h1);
    end
    // branch table: cached, uncached, long, delay slot, hold, return
    for (c = 0; c < 11; c++) begin
      step2(2);
      repeat (16) @(negedge mclk);
      d = nextRand();
      d[LOOP_HOLD_BIT] = HLD[c];
      logicWrite = 1'b1;
      logicData = d;
      @(negedge mclk);
      logicWrite = 1'b0;
      check({31'h0, loopHold}, {31'h0, HLD[c]});
      tgt = lastTake + 32'(OFF[c]);
      k = branch_kind_t'(KND[c]);
      branch = '{1'b1, k, DLY[c], tgt};
      expFlush = FLS[c];
      returnExec = (k == BR_RETURN);
      savedStatus = nextRand();
      @(negedge mclk);
      {branch, expFlush, returnExec} = '0;
      d[0] = (k == BR_SHORT_DELAYED || k == BR_LONG_DELAYED) ? HLD[c] :
             (k == BR_RETURN) ? savedStatus[LOOP_HOLD_BIT] : 1'b0;
      check({31'h0, loopHold}, {31'h0, d[0]});
      pc = tgt;
      dec(pc, 2'h3);
    end
    // frame clears the hold flag
    logicWrite = 1'b1;
    logicData = 32'h10;
    @(negedge mclk);
    logicWrite = 1'b0;
    frameExec = 1'b1;
    @(negedge mclk);
    frameExec = 1'b0;
    check({31'h0, loopHold}, 32'h0);
    close_out();
  end
endmodule : prefetch_cache_tb
